// ===== verilog/lpem_defines.svh
// Purpose: offsets, field positions, reset values of the link parameter and error monitor bank
// Assumes: byte-wide registers on the device's internal register port, 12-bit byte address
// Notes:   included by the package and by both design modules
//
// Functional notes
// - resolution field resets 0x1F, program 0x0F
// - bits-per-sample resets 0xF, kept at 0x0F
// - version 0 is rev A, 1 rev B
// - samples code 0 one, 1 two, reset zero
// - high density flag bit 7, resets set
// - checksum register eight bits, resets 0x45
// - lane pick bits 6:4 selects lane n
// - counters reached only through select then readback
// - kind 0 disparity, 1 not-in-table, 2 control
// - selected eight-bit counter returned through readback
`ifndef LPEM_DEFINES_SVH
`define LPEM_DEFINES_SVH

`define LPEM_ADDR_W             12
`define LPEM_OFF_RESOLUTION     12'h0457
`define LPEM_OFF_SAMPLES_FORMAT 12'h0458
`define LPEM_OFF_VERSION_SAMP   12'h0459
`define LPEM_OFF_DENSITY_CTRL   12'h045A
`define LPEM_OFF_PARAM_SUM      12'h045D
`define LPEM_OFF_ERR_SELECT     12'h046B

`define LPEM_RST_RESOLUTION     5'h1F
`define LPEM_RST_SUBCLASS       3'h1
`define LPEM_RST_BITS_PER_SAMP  5'h0F
`define LPEM_RST_VERSION        3'h1
`define LPEM_RST_SAMPLES        5'h00
`define LPEM_RST_HIGH_DENSITY   1'h1
`define LPEM_RST_CTRL_WORDS     5'h00
`define LPEM_RST_PARAM_SUM      8'h45

`define LPEM_VER_REV_A          3'h0
`define LPEM_VER_REV_B          3'h1
`define LPEM_SAMP_ONE           5'h00
`define LPEM_SAMP_TWO           5'h01

`define LPEM_LANES              8
`define LPEM_KIND_DISPARITY     2'h0
`define LPEM_KIND_NOT_IN_TABLE  2'h1
`define LPEM_KIND_UNEXP_CTRL    2'h2
`define LPEM_COUNT_MAX          8'hFF

`endif

// ===== verilog/lpem_pkg.sv
// Purpose: types of the link parameter and error monitor bank
// Assumes: constants live in lpem_defines.svh
// Notes:   none
`include "lpem_defines.svh"
package lpem_pkg;
   typedef logic [`LPEM_LANES-1:0][2:0][7:0] lpem_counts_type;

   typedef struct packed {
      lpem_counts_type counts;
   } lpem_cnt_state_type;

   typedef struct packed {
      logic [1:0] ctrl_bits;
      logic [4:0] resolution;
      logic [2:0] subclass;
      logic [4:0] bits_per_sample;
      logic [2:0] version;
      logic [4:0] samples;
      logic       high_density;
      logic [4:0] ctrl_words;
      logic [7:0] param_sum;
      logic [2:0] lane_pick;
      logic [1:0] kind_pick;
      logic [7:0] rdata;
      logic       rvalid;
   } lpem_state_type;
endpackage

// ===== verilog/lpem_err_counters.sv
// Purpose: per-lane saturating error counters with indirect selection
// Assumes: error strobes are one-cycle pulses from logic on clock_in
// Notes:   counters saturate rather than wrap so a burst never reads as few errors
`timescale 1ns/100ps
`include "lpem_defines.svh"
module lpem_err_counters
   import lpem_pkg::*;
(
   // clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   nrst_in,
   // error strobes, one bit per lane
   input  wire logic [`LPEM_LANES-1:0] disparity_error_in,
   input  wire logic [`LPEM_LANES-1:0] not_in_table_error_in,
   input  wire logic [`LPEM_LANES-1:0] unexpected_control_error_in,
   // selection and selected value
   input  wire logic [2:0]             monitored_lane_pick_in,
   input  wire logic [1:0]             counter_kind_pick_in,
   output logic      [7:0]             selected_count_out
);
   lpem_cnt_state_type state;
   lpem_cnt_state_type next_state;

   function automatic logic [7:0] lpem_sat_inc(input logic [7:0] value, input logic hit);
      lpem_sat_inc = (hit && value != `LPEM_COUNT_MAX) ? value + 8'h01 : value;
   endfunction

   always_comb begin
      next_state = state;
      for (int lane = 0; lane < `LPEM_LANES; lane++) begin
         next_state.counts[lane][0] = lpem_sat_inc(state.counts[lane][0], disparity_error_in[lane]);
         next_state.counts[lane][1] = lpem_sat_inc(state.counts[lane][1], not_in_table_error_in[lane]);
         next_state.counts[lane][2] = lpem_sat_inc(state.counts[lane][2], unexpected_control_error_in[lane]);
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // kind 3 is unused and reads zero
   always_comb begin
      case (counter_kind_pick_in)
         `LPEM_KIND_DISPARITY:    selected_count_out = state.counts[monitored_lane_pick_in][0];
         `LPEM_KIND_NOT_IN_TABLE: selected_count_out = state.counts[monitored_lane_pick_in][1];
         `LPEM_KIND_UNEXP_CTRL:   selected_count_out = state.counts[monitored_lane_pick_in][2];
         default:                 selected_count_out = 8'h00;
      endcase
   end

   AST_COUNT_SATURATES: assert property (@(posedge clock_in) disable iff (!nrst_in)
      state.counts[0][0] == `LPEM_COUNT_MAX |=> state.counts[0][0] == `LPEM_COUNT_MAX)
      else $error("disparity counter left saturation");
   AST_COUNT_INCREMENTS: assert property (@(posedge clock_in) disable iff (!nrst_in)
      disparity_error_in[0] && state.counts[0][0] != `LPEM_COUNT_MAX |=>
      state.counts[0][0] == $past(state.counts[0][0]) + 8'h01)
      else $error("disparity counter missed an event");
endmodule

// ===== verilog/lpem_regs.sv
// Purpose: lane 0 link parameter registers and error counter monitor select
// Assumes: one-cycle read and write strobes from the serial port decoder on clock_in
// Notes:   read data lands one cycle after the read strobe, marked by reg_rvalid_out
`timescale 1ns/100ps
`include "lpem_defines.svh"
module lpem_regs
   import lpem_pkg::*;
(
   // clock and reset
   input  wire logic                    clock_in,
   input  wire logic                    nrst_in,
   // register port
   input  wire logic [`LPEM_ADDR_W-1:0] reg_addr_in,
   input  wire logic [7:0]              reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic      [7:0]              reg_rdata_out,
   output logic                         reg_rvalid_out,
   // error strobes from the lane receivers
   input  wire logic [`LPEM_LANES-1:0]  disparity_error_in,
   input  wire logic [`LPEM_LANES-1:0]  not_in_table_error_in,
   input  wire logic [`LPEM_LANES-1:0]  unexpected_control_error_in,
   // expected link parameters
   output logic      [4:0]              converter_resolution_out,
   output logic      [1:0]              control_bits_out,
   output logic      [2:0]              subclass_version_out,
   output logic      [4:0]              total_bits_per_sample_out,
   output logic      [2:0]              link_standard_version_out,
   output logic                         link_rev_a_out,
   output logic                         link_rev_b_out,
   output logic      [1:0]              samples_per_frame_out,
   output logic                         samples_setting_ok_out,
   output logic                         high_density_flag_out,
   output logic      [4:0]              control_words_per_frame_out,
   output logic      [7:0]              lane_zero_param_sum_out,
   output logic      [2:0]              monitored_lane_pick_out,
   output logic      [1:0]              counter_kind_pick_out
);
   lpem_state_type state;
   lpem_state_type next_state;
   logic [7:0]     selected_count;

   function automatic logic lpem_hit(input logic [`LPEM_ADDR_W-1:0] addr, input logic [`LPEM_ADDR_W-1:0] off);
      lpem_hit = (addr == off);
   endfunction

   // counters are only visible through the select register, never directly
   lpem_err_counters u_counters (
      .clock_in                    (clock_in),
      .nrst_in                     (nrst_in),
      .disparity_error_in          (disparity_error_in),
      .not_in_table_error_in       (not_in_table_error_in),
      .unexpected_control_error_in (unexpected_control_error_in),
      .monitored_lane_pick_in      (state.lane_pick),
      .counter_kind_pick_in        (state.kind_pick),
      .selected_count_out          (selected_count)
   );

   always_comb begin
      next_state        = state;
      next_state.rvalid = reg_rd_in;
      next_state.rdata  = 8'h00;
      if (reg_wr_in) begin
         // reserved positions are simply not stored
         if (lpem_hit(reg_addr_in, `LPEM_OFF_RESOLUTION)) begin
            next_state.ctrl_bits  = reg_wdata_in[7:6];
            next_state.resolution = reg_wdata_in[4:0];
         end
         if (lpem_hit(reg_addr_in, `LPEM_OFF_SAMPLES_FORMAT)) begin
            next_state.subclass        = reg_wdata_in[7:5];
            next_state.bits_per_sample = reg_wdata_in[4:0];
         end
         if (lpem_hit(reg_addr_in, `LPEM_OFF_VERSION_SAMP)) begin
            next_state.version = reg_wdata_in[7:5];
            next_state.samples = reg_wdata_in[4:0];
         end
         if (lpem_hit(reg_addr_in, `LPEM_OFF_DENSITY_CTRL)) begin
            next_state.high_density = reg_wdata_in[7];
            next_state.ctrl_words   = reg_wdata_in[4:0];
         end
         // hardware does not check the sum, it only holds it
         if (lpem_hit(reg_addr_in, `LPEM_OFF_PARAM_SUM)) begin
            next_state.param_sum = reg_wdata_in;
         end
         if (lpem_hit(reg_addr_in, `LPEM_OFF_ERR_SELECT)) begin
            next_state.lane_pick = reg_wdata_in[6:4];
            next_state.kind_pick = reg_wdata_in[1:0];
         end
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `LPEM_OFF_RESOLUTION:     next_state.rdata = {state.ctrl_bits, 1'b0, state.resolution};
            `LPEM_OFF_SAMPLES_FORMAT: next_state.rdata = {state.subclass, state.bits_per_sample};
            `LPEM_OFF_VERSION_SAMP:   next_state.rdata = {state.version, state.samples};
            `LPEM_OFF_DENSITY_CTRL:   next_state.rdata = {state.high_density, 2'b00, state.ctrl_words};
            `LPEM_OFF_PARAM_SUM:      next_state.rdata = state.param_sum;
            // select fields are write-only, a read here returns the chosen counter
            `LPEM_OFF_ERR_SELECT:     next_state.rdata = selected_count;
            default:                  next_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         state                 <= '0;
         state.resolution      <= `LPEM_RST_RESOLUTION;
         state.subclass        <= `LPEM_RST_SUBCLASS;
         state.bits_per_sample <= `LPEM_RST_BITS_PER_SAMP;
         state.version         <= `LPEM_RST_VERSION;
         state.samples         <= `LPEM_RST_SAMPLES;
         state.high_density    <= `LPEM_RST_HIGH_DENSITY;
         state.ctrl_words      <= `LPEM_RST_CTRL_WORDS;
         state.param_sum       <= `LPEM_RST_PARAM_SUM;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata_out               = state.rdata;
   assign reg_rvalid_out              = state.rvalid;
   assign converter_resolution_out    = state.resolution;
   assign control_bits_out            = state.ctrl_bits;
   assign subclass_version_out        = state.subclass;
   assign total_bits_per_sample_out   = state.bits_per_sample;
   assign link_standard_version_out   = state.version;
   assign link_rev_a_out              = (state.version == `LPEM_VER_REV_A);
   assign link_rev_b_out              = (state.version == `LPEM_VER_REV_B);
   // an invalid samples code still reports one sample; the ok flag tells it apart
   assign samples_per_frame_out       = (state.samples == `LPEM_SAMP_TWO) ? 2'd2 : 2'd1;
   assign samples_setting_ok_out      = (state.samples == `LPEM_SAMP_ONE) || (state.samples == `LPEM_SAMP_TWO);
   assign high_density_flag_out       = state.high_density;
   assign control_words_per_frame_out = state.ctrl_words;
   assign lane_zero_param_sum_out     = state.param_sum;
   assign monitored_lane_pick_out     = state.lane_pick;
   assign counter_kind_pick_out       = state.kind_pick;

   AST_RESET_VALUES: assert property (@(posedge clock_in) !nrst_in |=>
      converter_resolution_out == 5'h1F && total_bits_per_sample_out == 5'h0F && high_density_flag_out)
      else $error("parameter reset values wrong");
   AST_SUM_RESET: assert property (@(posedge clock_in) !nrst_in |=> lane_zero_param_sum_out == 8'h45)
      else $error("checksum reset value wrong");
   AST_REV_B_AFTER_RESET: assert property (@(posedge clock_in) !nrst_in |=> link_rev_b_out && !link_rev_a_out)
      else $error("version does not decode rev B after reset");
   AST_TWO_SAMPLES: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h459 && reg_wdata_in[4:0] == 5'h01 |=> samples_per_frame_out == 2'd2)
      else $error("samples code 1 not decoded as two");
   AST_HD_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h45A |=> high_density_flag_out == $past(reg_wdata_in[7]))
      else $error("high density flag not written");
   AST_CF_RESERVED: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_rd_in && reg_addr_in == 12'h45A |=> reg_rvalid_out && reg_rdata_out[6:5] == 2'b00)
      else $error("density register reserved bits not zero");
   AST_LANE_PICK: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h46B ##1 !reg_wr_in [*2] |-> monitored_lane_pick_out == $past(reg_wdata_in[6:4], 2))
      else $error("lane pick not held");
   AST_READBACK: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_rd_in && reg_addr_in == 12'h46B |=> reg_rdata_out == $past(selected_count))
      else $error("readback not the selected counter");
   AST_UNMAPPED_ZERO: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_rd_in && reg_addr_in == 12'h45B |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");

   // reset values, one edge after reset is sampled low
   AST_RESET_PARAMS: assert property (@(posedge clock_in) !nrst_in |=>
      subclass_version_out == 3'h1 && control_words_per_frame_out == 5'h00 && control_bits_out == 2'h0)
      else $error("subclass or control fields reset wrong");
   AST_RESET_SAMPLES: assert property (@(posedge clock_in) !nrst_in |=>
      samples_per_frame_out == 2'd1 && samples_setting_ok_out)
      else $error("samples field reset wrong");
   AST_RESET_PICKS: assert property (@(posedge clock_in) !nrst_in |=>
      monitored_lane_pick_out == 3'h0 && counter_kind_pick_out == 2'h0 && !reg_rvalid_out)
      else $error("select fields or read valid not cleared by reset");

   // field writes show on the outputs right after the write edge
   AST_RES_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h457 |=> converter_resolution_out == $past(reg_wdata_in[4:0]))
      else $error("resolution not written");
   AST_CS_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h457 |=> control_bits_out == $past(reg_wdata_in[7:6]))
      else $error("control bits not written");
   AST_SUBCLASS_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h458 |=> subclass_version_out == $past(reg_wdata_in[7:5]))
      else $error("subclass version not written");
   AST_NP_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h458 |=> total_bits_per_sample_out == $past(reg_wdata_in[4:0]))
      else $error("bits per sample not written");
   AST_VERSION_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h459 |=> link_standard_version_out == $past(reg_wdata_in[7:5]))
      else $error("standard version not written");
   AST_REV_A: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h459 && reg_wdata_in[7:5] == 3'h0 |=> link_rev_a_out && !link_rev_b_out)
      else $error("version 0 not decoded as rev A");
   AST_ONE_SAMPLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h459 && reg_wdata_in[4:0] == 5'h00 |=> samples_per_frame_out == 2'd1)
      else $error("samples code 0 not decoded as one");
   AST_BAD_SAMPLES: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h459 && reg_wdata_in[4:0] > 5'h01 |=> !samples_setting_ok_out)
      else $error("invalid samples code reported as valid");
   AST_HD_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !(reg_wr_in && reg_addr_in == 12'h45A) |=> $stable(high_density_flag_out))
      else $error("high density flag changed without a write");
   AST_CF_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h45A |=> control_words_per_frame_out == $past(reg_wdata_in[4:0]))
      else $error("control words not written");
   AST_SUM_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h45D |=> lane_zero_param_sum_out == $past(reg_wdata_in))
      else $error("checksum not written");
   AST_SUM_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !(reg_wr_in && reg_addr_in == 12'h45D) |=> $stable(lane_zero_param_sum_out))
      else $error("checksum changed without a write");
   AST_KIND_PICK: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == 12'h46B |=> counter_kind_pick_out == $past(reg_wdata_in[1:0]))
      else $error("kind pick not written");

   // read port timing and counter readback
   AST_READ_LATENCY: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_rd_in |=> reg_rvalid_out)
      else $error("read valid missing one cycle after read");
   AST_RVALID_PULSE: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
      else $error("read data or valid stood without a read");
   AST_KIND3_ZERO: assert property (@(posedge clock_in) disable iff (!nrst_in)
      reg_rd_in && reg_addr_in == 12'h46B && counter_kind_pick_out == 2'h3 |=> reg_rdata_out == 8'h00)
      else $error("unused counter kind not zero");
endmodule

// ===== verification/lpem_regs_bench.sv
// Purpose: self-checking bench of the link parameter and error monitor bank
// Assumes: one-cycle strobes, read data one cycle after the read strobe
// Notes:   reads queue their expected byte; a watcher compares when rvalid appears
`timescale 1ns/100ps
`include "lpem_defines.svh"
module lpem_regs_bench;
   logic                    clock_in = 1'b0;
   logic                    nrst_in = 1'b0;
   logic [`LPEM_ADDR_W-1:0] reg_addr_in = 12'h0000;
   logic [7:0]              reg_wdata_in = 8'h00;
   logic                    reg_wr_in = 1'b0;
   logic                    reg_rd_in = 1'b0;
   logic [`LPEM_LANES-1:0]  dis_in = 8'h00;
   logic [`LPEM_LANES-1:0]  nit_in = 8'h00;
   logic [`LPEM_LANES-1:0]  uec_in = 8'h00;
   logic [7:0]              reg_rdata_out, sum_out;
   logic                    reg_rvalid_out, rev_a_out, rev_b_out, ok_out, hd_out;
   logic [4:0]              res_out, bps_out, cw_out;
   logic [2:0]              sub_out, ver_out, lane_out;
   logic [1:0]              cb_out, spf_out, kind_out;
   logic [31:0]             seed = 32'h0000_0014;
   logic [7:0]              notes[$];
   int                      miscompares = 0;
   int                      compares = 0;
   int                      cnt[8][3];

   lpem_regs lpem_regs_i (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .disparity_error_in(dis_in), .not_in_table_error_in(nit_in),
      .unexpected_control_error_in(uec_in), .converter_resolution_out(res_out), .control_bits_out(cb_out),
      .subclass_version_out(sub_out), .total_bits_per_sample_out(bps_out), .link_standard_version_out(ver_out),
      .link_rev_a_out(rev_a_out), .link_rev_b_out(rev_b_out), .samples_per_frame_out(spf_out),
      .samples_setting_ok_out(ok_out), .high_density_flag_out(hd_out), .control_words_per_frame_out(cw_out),
      .lane_zero_param_sum_out(sum_out), .monitored_lane_pick_out(lane_out), .counter_kind_pick_out(kind_out));

   always #2 clock_in = ~clock_in;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
      compares++;
      if (got !== e) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, e);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clock_in);
      reg_wr_in    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      notes.push_back(e);
      @(posedge clock_in);
      reg_rd_in   <= 1'b0;
      #1;
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watcher: oldest note pairs with each read result
   // falling edge: the read pulse is settled and not yet being replaced
   always @(negedge clock_in) begin
      if (reg_rvalid_out === 1'b1) begin
         if (notes.size() == 0)
            chk(8'h01, 8'h00, "read data without request");
         else
            chk(reg_rdata_out, notes.pop_front(), "read data");
      end
   end

   initial begin
      repeat (50000) @(posedge clock_in);
      miscompares++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run();
   end

   initial begin
      logic [31:0] r;
      logic [7:0]  s8;
      logic [7:0]  e;
      repeat (16) @(posedge clock_in);
      nrst_in <= 1'b1;
      rd(12'h0457, 8'h1F);
      rd(12'h0458, 8'h2F);
      rd(12'h0459, 8'h20);
      rd(12'h045A, 8'h80);
      rd(12'h045D, 8'h45);
      chk(rev_b_out, 8'h01, "rev b after reset");
      chk(spf_out, 8'h01, "one sample after reset");
      chk(sub_out, 8'h01, "subclass after reset");
      chk(bps_out, 8'h0F, "bits per sample after reset");
      chk(cw_out, 8'h00, "control words after reset");
      chk(cb_out, 8'h00, "control bits after reset");
      $display("test reset values done");
      wr(12'h0457, 8'hFF);
      chk(cb_out, 8'h03, "control bits");
      rd(12'h0457, 8'hDF);
      wr(12'h0457, 8'h0F);
      chk(res_out, 8'h0F, "resolution");
      wr(12'h045A, 8'hFF);
      chk(cw_out, 8'h1F, "control words");
      rd(12'h045A, 8'h9F);
      wr(12'h045A, 8'h00);
      chk(hd_out, 8'h00, "density flag cleared");
      r = xs();
      wr(12'h0458, r[7:0]);
      chk(sub_out, r[7:5], "subclass");
      chk(bps_out, r[4:0], "bits per sample");
      rd(12'h0458, r[7:0]);
      wr(12'h0458, 8'h2F);
      $display("test field access done");
      for (int v = 0; v < 8; v++) begin
         for (int k = 0; k < 4; k++) begin
            s8 = (k == 3) ? 8'h1F : k[7:0];
            wr(12'h0459, {v[2:0], s8[4:0]});
            chk(ver_out, v[7:0], "version");
            chk(rev_a_out, (v == 0), "rev a decode");
            chk(rev_b_out, (v == 1), "rev b decode");
            chk(spf_out, (s8 == 8'h01) ? 8'h02 : 8'h01, "samples decode");
            chk(ok_out, (s8 <= 8'h01), "samples valid");
         end
      end
      wr(12'h0459, 8'h20);
      // registers 0x450..0x456 live outside this bank; sum covers what it holds
      e = 8'h0F + 8'h2F + 8'h20 + 8'h00;
      wr(12'h045D, e);
      chk(sum_out, e, "checksum out");
      rd(12'h045D, e);
      $display("test decode and checksum done");
      // lane 0 disparity forced high so its counter must saturate
      for (int c = 0; c < 300; c++) begin
         r = xs() | 32'h0000_0001;
         @(posedge clock_in);
         dis_in <= r[7:0];
         nit_in <= r[15:8];
         uec_in <= r[23:16];
         for (int l = 0; l < 8; l++) begin
            cnt[l][0] += r[l];
            cnt[l][1] += r[8 + l];
            cnt[l][2] += r[16 + l];
         end
      end
      @(posedge clock_in);
      dis_in <= 8'h00;
      nit_in <= 8'h00;
      uec_in <= 8'h00;
      for (int l = 0; l < 8; l++) begin
         for (int k = 0; k < 4; k++) begin
            wr(12'h046B, {1'b1, l[2:0], 2'b11, k[1:0]});
            chk(lane_out, l[7:0], "lane pick");
            chk(kind_out, k[7:0], "kind pick");
            e = (k == 3) ? 8'h00 : ((cnt[l][k % 3] > 255) ? 8'hFF : cnt[l][k % 3]);
            rd(12'h046B, e);
         end
      end
      rd(12'h0460, 8'h00);
      rd(12'h045B, 8'h00);
      $display("test error counters done");
      // second reset in mid-run must clear counters and restore the checksum
      @(posedge clock_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      @(posedge clock_in);
      wr(12'h046B, 8'h00);
      chk(sum_out, 8'h45, "checksum after second reset");
      rd(12'h046B, 8'h00);
      rd(12'h0457, 8'h1F);
      $display("test second reset done");
      for (int i = 0; i < 8 && notes.size() != 0; i++) @(posedge clock_in);
      if (notes.size() != 0) begin
         miscompares++;
         $display("unexpected at %0t: reads left unanswered", $time);
      end
      complete_run();
   end
endmodule
